// ---- dv/ralu_cal_model.sv ----
// Stand-in for the calendar counters that sit beside the alarm unit.
// Assumes the bench asks for each minute rollover with a one-cycle step request.
`timescale 1ns/1ps
`default_nettype none
module ralu_cal_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic [7:0] nxt_min,
  input wire logic [7:0] nxt_hour,
  input wire logic [7:0] nxt_date,
  input wire logic [6:0] nxt_wday,
  output logic minute_tick,
  output logic [7:0] cur_min,
  output logic [7:0] cur_hour,
  output logic [7:0] cur_date,
  output logic [6:0] cur_wday
);
  // The new time and the tick land on the same edge, so the tick cycle already shows the new minute.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      minute_tick <= 1'b0;
      cur_min <= 8'h00;
      cur_hour <= 8'h00;
      cur_date <= 8'h01;
      cur_wday <= 7'h01;
    end else begin
      minute_tick <= step;
      if (step) begin
        cur_min <= nxt_min;
        cur_hour <= nxt_hour;
        cur_date <= nxt_date;
        cur_wday <= nxt_wday;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_rtc_alarm_interrupt_unit.sv ----
// Self-checking bench for the alarm unit: register tasks plus a calendar stand-in.
// Assumes a 10 MHz clock and the open-drain pin pulled up on the board.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_rtc_alarm_interrupt_unit;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic step = 1'b0;
  logic [7:0] n_min = 8'h00;
  logic [7:0] n_hour = 8'h00;
  logic [7:0] n_date = 8'h01;
  logic [6:0] n_wday = 7'h01;
  logic minute_tick;
  logic [7:0] cur_min;
  logic [7:0] cur_hour;
  logic [7:0] cur_date;
  logic [6:0] cur_wday;
  logic pin_out;
  logic pin_oe;
  logic [7:0] rd_val;
  logic [7:0] wmask = 8'h3E;
  int miscompares = 0;
  int total_checks = 0;
  wire irq_wire;
  // The pin is open drain; the board pull-up gives high while nobody drives it.
  assign irq_wire = pin_oe ? pin_out : 1'b1;
  always #50 sys_clk = ~sys_clk;

  ralu_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .minute_tick(minute_tick),
    .cur_min(cur_min), .cur_hour(cur_hour), .cur_date(cur_date), .cur_wday(cur_wday),
    .irq_out_primary_in(irq_wire), .irq_out_primary_out(pin_out), .irq_out_primary_oe(pin_oe));
  ralu_cal_model cal (.sys_clk(sys_clk), .rst_n(rst_n), .step(step), .nxt_min(n_min),
    .nxt_hour(n_hour), .nxt_date(n_date), .nxt_wday(n_wday), .minute_tick(minute_tick),
    .cur_min(cur_min), .cur_hour(cur_hour), .cur_date(cur_date), .cur_wday(cur_wday));

  // ----------------------------------------
  // Register port, pin, rollover and summary tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    `CHK(nm, e, rd_val)
  endtask
  task automatic pin_is(input logic e);
    @(posedge sys_clk);
    #1 `CHK("irq pin", e, irq_wire)
  endtask
  // One minute rollover, then the pin is checked one edge after the tick is taken and the flag is read back next.
  task automatic roll(input logic [7:0] m, input logic [7:0] h, input logic [7:0] dt, input logic [6:0] wd,
    input logic ef, input logic ep, input logic clr);
    @(posedge sys_clk);
    n_min <= m;
    n_hour <= h;
    n_date <= dt;
    n_wday <= wd;
    step <= 1'b1;
    @(posedge sys_clk);
    step <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("irq pin", ~ep, irq_wire)
    chk_rd("alarm flag", ralu_pkg::ADDR_EVT_FLAGS, {4'h0, ef, 3'h0});
    if (clr) begin
      wr(ralu_pkg::ADDR_EVT_FLAGS, 8'h00);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_rd("reset main", ralu_pkg::ADDR_MAIN_CTRL, 8'h00);
    chk_rd("unmapped", 8'h20, 8'h00);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h00);
    wr(ralu_pkg::ADDR_MIN_ALARM, 8'h59);
    chk_rd("min alarm", ralu_pkg::ADDR_MIN_ALARM, 8'h59);
    wr(ralu_pkg::ADDR_HOUR_ALARM, 8'h80);
    wr(ralu_pkg::ADDR_WDAY_ALARM, 8'h80);
    wr(ralu_pkg::ADDR_EVT_FLAGS, 8'hFF);
    chk_rd("flag set by write", ralu_pkg::ADDR_EVT_FLAGS, 8'h00);
    roll(8'h59, 8'h07, 8'h01, 7'h01, 1'b1, 1'b0, 1'b1);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h08);
    roll(8'h00, 8'h08, 8'h01, 7'h01, 1'b0, 1'b0, 1'b1);
    roll(8'h59, 8'h08, 8'h01, 7'h01, 1'b1, 1'b1, 1'b0);
    repeat (30) @(posedge sys_clk);
    pin_is(1'b0);
    wr(ralu_pkg::ADDR_EVT_FLAGS, 8'h08);
    chk_rd("flag kept", ralu_pkg::ADDR_EVT_FLAGS, 8'h08);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h00);
    pin_is(1'b1);
    chk_rd("flag after enable off", ralu_pkg::ADDR_EVT_FLAGS, 8'h08);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h08);
    wr(ralu_pkg::ADDR_EVT_FLAGS, 8'h00);
    roll(8'h59, 8'h09, 8'h01, 7'h01, 1'b1, 1'b1, 1'b1);
    pin_is(1'b1);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h48);
    roll(8'h59, 8'h10, 8'h01, 7'h01, 1'b0, 1'b0, 1'b1);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h08);
    wr(ralu_pkg::ADDR_MIN_ALARM, 8'h80);
    roll(8'h01, 8'h11, 8'h01, 7'h01, 1'b1, 1'b1, 1'b1);
    roll(8'h02, 8'h11, 8'h01, 7'h01, 1'b1, 1'b1, 1'b1);
    wr(ralu_pkg::ADDR_MIN_ALARM, 8'h02);
    wr(ralu_pkg::ADDR_HOUR_ALARM, 8'h11);
    repeat (5) @(posedge sys_clk);
    chk_rd("present time", ralu_pkg::ADDR_EVT_FLAGS, 8'h00);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h00);
    wr(ralu_pkg::ADDR_MIN_ALARM, 8'h00);
    wr(ralu_pkg::ADDR_HOUR_ALARM, 8'h80);
    wr(ralu_pkg::ADDR_WDAY_ALARM, wmask);
    wr(ralu_pkg::ADDR_EXT_CTRL, 8'h00);
    wr(ralu_pkg::ADDR_MAIN_CTRL, 8'h08);
    for (int d = 0; d < 7; d++) begin
      roll(8'h00, 8'h07, 8'h01, 7'(1 << d), wmask[d], wmask[d], 1'b1);
    end
    wr(ralu_pkg::ADDR_EXT_CTRL, 8'h08);
    chk_rd("date select", ralu_pkg::ADDR_EXT_CTRL, 8'h08);
    wr(ralu_pkg::ADDR_WDAY_ALARM, 8'h15);
    roll(8'h00, 8'h07, 8'h15, 7'h01, 1'b1, 1'b1, 1'b1);
    roll(8'h00, 8'h07, 8'h14, 7'h01, 1'b0, 1'b0, 1'b1);
    wr(ralu_pkg::ADDR_WDAY_ALARM, 8'h95);
    roll(8'h00, 8'h07, 8'h14, 7'h01, 1'b1, 1'b1, 1'b1);
    summarize();
  end

  // A stuck handshake must not hang the run; the tests need well under 2000 cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire

// ---- rtl/ralu_cmp_if.sv ----
// Interface carrying alarm settings and the present calendar to the comparator.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface ralu_cmp_if;
  logic [7:0] min_alarm;
  logic [7:0] hour_alarm;
  logic [7:0] wday_alarm;
  logic wday_sel;
  logic [7:0] cur_min;
  logic [7:0] cur_hour;
  logic [7:0] cur_date;
  logic [6:0] cur_wday;
  logic match;
  modport ctrl (output min_alarm, hour_alarm, wday_alarm, wday_sel, cur_min, cur_hour, cur_date, cur_wday,
    input match);
  modport cmp (input min_alarm, hour_alarm, wday_alarm, wday_sel, cur_min, cur_hour, cur_date, cur_wday,
    output match);
endinterface
`default_nettype wire

// ---- rtl/ralu_compare.sv ----
// Combinational alarm comparator: field excludes and weekday-or-date selection.
// Assumes BCD time fields and a one-hot weekday from the calendar counters.
`timescale 1ns/1ps
`default_nettype none
module ralu_compare (
  ralu_cmp_if.cmp cif
);
  logic min_ok;
  logic hour_ok;
  logic day_ok;

  always_comb begin
    // An excluded field always agrees, so all three excluded matches every minute.
    min_ok = cif.min_alarm[ralu_pkg::EXCL_BIT] ||
             ((cif.min_alarm & ralu_pkg::MIN_FIELD_MASK) == (cif.cur_min & ralu_pkg::MIN_FIELD_MASK));
    hour_ok = cif.hour_alarm[ralu_pkg::EXCL_BIT] ||
              ((cif.hour_alarm & ralu_pkg::HOUR_FIELD_MASK) == (cif.cur_hour & ralu_pkg::HOUR_FIELD_MASK));
    if (cif.wday_alarm[ralu_pkg::EXCL_BIT]) begin
      day_ok = 1'b1;
    end else if (cif.wday_sel) begin
      day_ok = (cif.wday_alarm & ralu_pkg::DATE_FIELD_MASK) == (cif.cur_date & ralu_pkg::DATE_FIELD_MASK);
    end else begin
      day_ok = |(cif.wday_alarm[6:0] & cif.cur_wday);
    end
    cif.match = min_ok && hour_ok && day_ok;
  end
endmodule
`default_nettype wire

// ---- rtl/ralu_pkg.sv ----
// Package for the alarm interrupt unit: register offsets, field positions and timing constants.
// Assumes a byte-wide register port with offsets as printed (no public bus).
package ralu_pkg;
  localparam logic [7:0] ADDR_MIN_ALARM = 8'h18;
  localparam logic [7:0] ADDR_HOUR_ALARM = 8'h19;
  localparam logic [7:0] ADDR_WDAY_ALARM = 8'h1A;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h1D;
  localparam logic [7:0] ADDR_EVT_FLAGS = 8'h1E;
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h1F;
  localparam int EXCL_BIT = 7;
  localparam int WDSEL_BIT = 3;
  localparam int AFLAG_BIT = 3;
  localparam int ALARM_IRQ_ENABLE_BIT = 3;
  localparam int STOP_BIT = 6;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MIN_FIELD_MASK = 8'h7F;
  localparam logic [7:0] HOUR_FIELD_MASK = 8'h3F;
  localparam logic [7:0] DATE_FIELD_MASK = 8'h3F;
  localparam logic [6:0] DAY_MASK_WIDTH_ONE = 7'h01;
  localparam real CLK_PERIOD_NS = 100.0;
  localparam real MAX_LATENCY_NS = 1460000.0;
  localparam int MAX_LATENCY_CYC = int'(MAX_LATENCY_NS / CLK_PERIOD_NS) - 1;
endpackage

// ---- rtl/ralu_top.sv ----
// Alarm interrupt unit of a real-time clock: alarm registers, flag, enable and open-drain interrupt pin.
// Assumes the calendar counters supply BCD time and a minute rollover pulse; host uses a plain byte port.
//
// Operation
// - Match sets flag and drives pin low.
// - Flag and pin change within 1.46 ms.
// - Alarm low holds until software releases.
// - Stop bit suppresses alarm events.
// - Alarm registers usable as storage; host keeps enable zero.
// - Select bit picks weekday mask or date.
// - Weekday mask bit 0 Sunday to bit 6.
// - Exclude bit removes field from comparison.
// - All excluded gives event every minute.
// - Writing present time gives no immediate event.
// - Flag sets on event, stays until cleared.
// - Writing zero clears flag and releases pin.
// - Writing one to flag does nothing.
// - Enable one lets event pull pin low.
// - Writing enable zero releases the pin.
// - Enable gates pin only, not flag.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ralu_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic minute_tick,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_date,
  input wire logic [6:0] cur_wday,
  input wire logic irq_out_primary_in,
  output logic irq_out_primary_out,
  output logic irq_out_primary_oe
);
  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [7:0] min_alarm_ff;
  logic [7:0] hour_alarm_ff;
  logic [7:0] wday_alarm_ff;
  logic [7:0] ext_ctrl_ff;
  logic [7:0] main_ctrl_ff;
  logic alarm_event_flag_ff;
  logic [7:0] reg_rdata_ff;
  logic irq_oe_ff;
  logic [7:0] nxt_rdata;
  logic alarm_event;
  logic flag_clr;
  logic irq_enable_clr;

  ralu_cmp_if cif();

  assign cif.min_alarm = min_alarm_ff;
  assign cif.hour_alarm = hour_alarm_ff;
  assign cif.wday_alarm = wday_alarm_ff;
  assign cif.wday_sel = ext_ctrl_ff[ralu_pkg::WDSEL_BIT];
  assign cif.cur_min = cur_min;
  assign cif.cur_hour = cur_hour;
  assign cif.cur_date = cur_date;
  assign cif.cur_wday = cur_wday;

  ralu_compare u_cmp (
    .cif(cif)
  );

  // Writes to the alarm registers are plain storage; they are compared even when used as RAM.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      min_alarm_ff <= ralu_pkg::ALARM_RESET;
      hour_alarm_ff <= ralu_pkg::ALARM_RESET;
      wday_alarm_ff <= ralu_pkg::ALARM_RESET;
      ext_ctrl_ff <= ralu_pkg::CTRL_RESET;
      main_ctrl_ff <= ralu_pkg::CTRL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ralu_pkg::ADDR_MIN_ALARM) begin
        min_alarm_ff <= reg_wdata;
      end else if (reg_addr == ralu_pkg::ADDR_HOUR_ALARM) begin
        hour_alarm_ff <= reg_wdata;
      end else if (reg_addr == ralu_pkg::ADDR_WDAY_ALARM) begin
        wday_alarm_ff <= reg_wdata;
      end else if (reg_addr == ralu_pkg::ADDR_EXT_CTRL) begin
        ext_ctrl_ff <= reg_wdata;
      end else if (reg_addr == ralu_pkg::ADDR_MAIN_CTRL) begin
        main_ctrl_ff <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Alarm event and flag
  // ---------------------------------------------------------------------------
  // Sampling only on the rollover means a write of the present time cannot fire until the
  // counters step into it again.
  assign alarm_event = minute_tick && cif.match && !main_ctrl_ff[ralu_pkg::STOP_BIT];
  assign flag_clr = reg_wr && (reg_addr == ralu_pkg::ADDR_EVT_FLAGS) && !reg_wdata[ralu_pkg::AFLAG_BIT];
  assign irq_enable_clr = reg_wr && (reg_addr == ralu_pkg::ADDR_MAIN_CTRL) &&
                          !reg_wdata[ralu_pkg::ALARM_IRQ_ENABLE_BIT];

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_event_flag_ff <= 1'b0;
    end else if (alarm_event) begin
      alarm_event_flag_ff <= 1'b1;
    end else if (flag_clr) begin
      alarm_event_flag_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Open-drain interrupt pin
  // ---------------------------------------------------------------------------
  // The pin only ever drives low; released means output enable off. Nothing but a software
  // write ends the low, so a missed clear leaves the line asserted for good.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_oe_ff <= 1'b0;
    end else if (alarm_event && main_ctrl_ff[ralu_pkg::ALARM_IRQ_ENABLE_BIT] && !irq_enable_clr) begin
      irq_oe_ff <= 1'b1;
    end else if (flag_clr || irq_enable_clr || !main_ctrl_ff[ralu_pkg::ALARM_IRQ_ENABLE_BIT]) begin
      irq_oe_ff <= 1'b0;
    end
  end

  assign irq_out_primary_oe = irq_oe_ff;
  assign irq_out_primary_out = 1'b0;

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == ralu_pkg::ADDR_MIN_ALARM) begin
      nxt_rdata = min_alarm_ff;
    end else if (reg_addr == ralu_pkg::ADDR_HOUR_ALARM) begin
      nxt_rdata = hour_alarm_ff;
    end else if (reg_addr == ralu_pkg::ADDR_WDAY_ALARM) begin
      nxt_rdata = wday_alarm_ff;
    end else if (reg_addr == ralu_pkg::ADDR_EXT_CTRL) begin
      nxt_rdata = ext_ctrl_ff;
    end else if (reg_addr == ralu_pkg::ADDR_EVT_FLAGS) begin
      nxt_rdata[ralu_pkg::AFLAG_BIT] = alarm_event_flag_ff;
    end else if (reg_addr == ralu_pkg::ADDR_MAIN_CTRL) begin
      nxt_rdata = main_ctrl_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_event_sets_flag;
    @(posedge sys_clk) disable iff (!rst_n) alarm_event |=> alarm_event_flag_ff;
  endproperty
  a_event_sets_flag: assert property (p_event_sets_flag) else $error("alarm flag not set");

  property p_pin_latency;
    @(posedge sys_clk) disable iff (!rst_n)
      (alarm_event && main_ctrl_ff[ralu_pkg::ALARM_IRQ_ENABLE_BIT] && !irq_enable_clr) |-> ##[1:2] irq_out_primary_oe;
  endproperty
  a_pin_latency: assert property (p_pin_latency) else $error("pin too slow");

  property p_pin_holds;
    @(posedge sys_clk) disable iff (!rst_n)
      (irq_oe_ff && !flag_clr && !irq_enable_clr) |=> irq_oe_ff;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("pin released on its own");

  property p_stop_blocks;
    @(posedge sys_clk) disable iff (!rst_n)
      (main_ctrl_ff[ralu_pkg::STOP_BIT] && !alarm_event_flag_ff) |=> !alarm_event_flag_ff;
  endproperty
  a_stop_blocks: assert property (p_stop_blocks) else $error("event while stopped");

  property p_no_tick_no_set;
    @(posedge sys_clk) disable iff (!rst_n) (!minute_tick && !alarm_event_flag_ff) |=> !alarm_event_flag_ff;
  endproperty
  a_no_tick_no_set: assert property (p_no_tick_no_set) else $error("flag set off rollover");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (!rst_n) (flag_clr && !alarm_event) |=> (!alarm_event_flag_ff && !irq_oe_ff);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("clear failed");

  property p_one_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == ralu_pkg::ADDR_EVT_FLAGS && reg_wdata[ralu_pkg::AFLAG_BIT])
      |=> (alarm_event_flag_ff == ($past(alarm_event_flag_ff) || $past(alarm_event)));
  endproperty
  a_one_write: assert property (p_one_write) else $error("write one changed flag");

  property p_enable_off;
    @(posedge sys_clk) disable iff (!rst_n) irq_enable_clr |=> (!irq_oe_ff ##1 !irq_oe_ff);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("pin kept low");

  property p_pin_implies_flag;
    @(posedge sys_clk) disable iff (!rst_n) irq_oe_ff |-> alarm_event_flag_ff;
  endproperty
  a_pin_implies_flag: assert property (p_pin_implies_flag) else $error("pin low without flag");

  // Restated views of the stored alarm settings, kept apart from the comparator so that a
  // slip in its field masks or in the day select shows up here.
  logic min_agrees;
  logic hour_agrees;
  logic day_excluded;
  logic date_selected;
  logic wday_hit;
  logic date_same;
  logic stopped;
  logic irq_enabled;
  assign min_agrees = min_alarm_ff[ralu_pkg::EXCL_BIT] ||
                      ((min_alarm_ff & ralu_pkg::MIN_FIELD_MASK) == (cur_min & ralu_pkg::MIN_FIELD_MASK));
  assign hour_agrees = hour_alarm_ff[ralu_pkg::EXCL_BIT] ||
                       ((hour_alarm_ff & ralu_pkg::HOUR_FIELD_MASK) == (cur_hour & ralu_pkg::HOUR_FIELD_MASK));
  assign day_excluded = wday_alarm_ff[ralu_pkg::EXCL_BIT];
  assign date_selected = ext_ctrl_ff[ralu_pkg::WDSEL_BIT];
  assign wday_hit = |(wday_alarm_ff[6:0] & cur_wday);
  assign date_same = (wday_alarm_ff & ralu_pkg::DATE_FIELD_MASK) == (cur_date & ralu_pkg::DATE_FIELD_MASK);
  assign stopped = main_ctrl_ff[ralu_pkg::STOP_BIT];
  assign irq_enabled = main_ctrl_ff[ralu_pkg::ALARM_IRQ_ENABLE_BIT];

  property p_flag_rises_on_event;
    @(posedge sys_clk) disable iff (!rst_n)
      (!alarm_event_flag_ff && !alarm_event) |=> !alarm_event_flag_ff;
  endproperty
  a_flag_rises_on_event: assert property (p_flag_rises_on_event) else $error("flag set without event");

  property p_flag_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      (alarm_event_flag_ff && !flag_clr) |=> alarm_event_flag_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped on its own");

  property p_set_beats_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (alarm_event && flag_clr) |=> alarm_event_flag_ff;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("event lost to clear");

  property p_all_excluded;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !stopped && min_alarm_ff[ralu_pkg::EXCL_BIT] && hour_alarm_ff[ralu_pkg::EXCL_BIT] &&
       day_excluded) |=> alarm_event_flag_ff;
  endproperty
  a_all_excluded: assert property (p_all_excluded) else $error("no event with all fields excluded");

  property p_weekday_hit;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !stopped && min_agrees && hour_agrees && !day_excluded && !date_selected && wday_hit)
      |=> alarm_event_flag_ff;
  endproperty
  a_weekday_hit: assert property (p_weekday_hit) else $error("weekday match missed");

  property p_weekday_miss;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !alarm_event_flag_ff && !day_excluded && !date_selected && !wday_hit) |=> !alarm_event_flag_ff;
  endproperty
  a_weekday_miss: assert property (p_weekday_miss) else $error("event on unselected weekday");

  property p_date_hit;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !stopped && min_agrees && hour_agrees && !day_excluded && date_selected && date_same)
      |=> alarm_event_flag_ff;
  endproperty
  a_date_hit: assert property (p_date_hit) else $error("date match missed");

  property p_date_miss;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !alarm_event_flag_ff && !day_excluded && date_selected && !date_same) |=> !alarm_event_flag_ff;
  endproperty
  a_date_miss: assert property (p_date_miss) else $error("event on wrong date");

  property p_minute_miss;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !alarm_event_flag_ff && !min_agrees) |=> !alarm_event_flag_ff;
  endproperty
  a_minute_miss: assert property (p_minute_miss) else $error("event on wrong minute");

  property p_hour_excluded;
    @(posedge sys_clk) disable iff (!rst_n)
      (minute_tick && !stopped && min_agrees && hour_alarm_ff[ralu_pkg::EXCL_BIT] && day_excluded)
      |=> alarm_event_flag_ff;
  endproperty
  a_hour_excluded: assert property (p_hour_excluded) else $error("excluded field still compared");

  property p_stop_keeps_pin;
    @(posedge sys_clk) disable iff (!rst_n)
      (stopped && !irq_oe_ff) |=> !irq_oe_ff;
  endproperty
  a_stop_keeps_pin: assert property (p_stop_keeps_pin) else $error("pin low while stopped");

  property p_enable_gates_pin;
    @(posedge sys_clk) disable iff (!rst_n)
      !irq_enabled |-> !irq_oe_ff;
  endproperty
  a_enable_gates_pin: assert property (p_enable_gates_pin) else $error("pin low with enable off");

  property p_enable_keeps_flag;
    @(posedge sys_clk) disable iff (!rst_n)
      (irq_enable_clr && alarm_event_flag_ff) |=> alarm_event_flag_ff;
  endproperty
  a_enable_keeps_flag: assert property (p_enable_keeps_flag) else $error("enable write cleared flag");

  property p_flag_without_pin;
    @(posedge sys_clk) disable iff (!rst_n)
      (alarm_event && !irq_enabled) |=> (alarm_event_flag_ff && !irq_oe_ff);
  endproperty
  a_flag_without_pin: assert property (p_flag_without_pin) else $error("enable gated the flag");

  property p_alarm_write_stores;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && (reg_addr == ralu_pkg::ADDR_MIN_ALARM)) |=> (min_alarm_ff == $past(reg_wdata));
  endproperty
  a_alarm_write_stores: assert property (p_alarm_write_stores) else $error("alarm write lost");

  property p_alarm_read_back;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && (reg_addr == ralu_pkg::ADDR_WDAY_ALARM)) |=> (reg_rdata == $past(wday_alarm_ff));
  endproperty
  a_alarm_read_back: assert property (p_alarm_read_back) else $error("alarm read back wrong");

  property p_flag_read_back;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && (reg_addr == ralu_pkg::ADDR_EVT_FLAGS)) |=>
      (reg_rdata[ralu_pkg::AFLAG_BIT] == $past(alarm_event_flag_ff));
  endproperty
  a_flag_read_back: assert property (p_flag_read_back) else $error("flag read back wrong");

  property p_select_stores;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && (reg_addr == ralu_pkg::ADDR_EXT_CTRL)) |=> (date_selected == $past(reg_wdata[ralu_pkg::WDSEL_BIT]));
  endproperty
  a_select_stores: assert property (p_select_stores) else $error("day select not stored");
endmodule
`default_nettype wire
